// ---- svs_select_reg.sv ----
// Secondary verification select register with mode-gated check outputs.
`timescale 1ns/1ns
`include "svs_defines.svh"
// Function
// - Select field picks one secondary supervision self-test to activate.
// - Code zero activates no verification function.
// - Codes 1,2,3 select desaturation_check level 1, desaturation_check level 2, overcurrent level 1.
// - Codes 4 to 7 select supply 2 and 3 under/over-voltage checks.
// - Code 8 activates the timing check test.
// - Code 9 selects desaturation_check level 3, code A overcurrent level 3.
// - Selection applies only on entering verification mode.
// - Select field clears to zero on entering entry mode.
// - Bit 1 reports whether the previous message was discarded.
// - Bit 0 carries odd parity over the returned word.
module svs_select_reg
	import svs_pkg::*;
#(
	parameter int ADDR_W = 5,
	parameter int NUM_CHECKS = `SVS_NUM_CHECKS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [15:0] wr_data,
	input wire logic msg_done,
	input wire logic msg_discarded,
	input wire logic verification_operating_mode,
	input wire logic entry_operating_mode,
	output logic [15:0] rd_data,
	output logic [3:0] active_code,
	output logic [NUM_CHECKS-1:0] check_active
);
	svs_code_t sel_reg;
	svs_code_t sel_next;
	svs_code_t act_reg;
	svs_code_t act_next;
	logic lmi_reg;
	logic lmi_next;
	logic vmode_d_reg;
	logic vmode_d_next;
	logic emode_d_reg;
	logic emode_d_next;
	svs_state_e state_reg;
	svs_state_e state_next;
	logic [NUM_CHECKS-1:0] chk_reg;
	logic [NUM_CHECKS-1:0] chk_next;
	logic [14:0] body;
	logic par;

	function automatic logic code_hit(input svs_code_t c, input int idx);
		code_hit = (c == svs_code_t'(idx + 1));
	endfunction

	always_comb
	begin
		vmode_d_next = verification_operating_mode;
		emode_d_next = entry_operating_mode;
		sel_next = sel_reg;
		act_next = act_reg;
		state_next = state_reg;
		lmi_next = lmi_reg;
		if (msg_done)
			lmi_next = msg_discarded;
		if (wr_en && wr_addr == ADDR_W'(`SVS_REG_OFFSET))
			sel_next = wr_data[`SVS_SEL_MSB:`SVS_SEL_LSB];
		if (entry_operating_mode && !emode_d_reg)
			sel_next = `SVS_CODE_NONE;
		case (state_reg)
			SVS_IDLE:
			begin
				act_next = `SVS_CODE_NONE;
				if (verification_operating_mode && !vmode_d_reg)
				begin
					act_next = sel_reg;
					state_next = SVS_ARMED;
				end
			end
			SVS_ARMED:
			begin
				if (!verification_operating_mode)
				begin
					act_next = `SVS_CODE_NONE;
					state_next = SVS_IDLE;
				end
			end
			default:
			begin
				act_next = `SVS_CODE_NONE;
				state_next = SVS_IDLE;
			end
		endcase
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CHECKS; gi++)
		begin : g_chk
			// Codes 1..A map to one-hot index 0..9; zero or above A gives none.
			always_comb
			begin
				chk_next[gi] = code_hit(act_next, gi);
			end
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sel_reg <= `SVS_CODE_NONE;
			act_reg <= `SVS_CODE_NONE;
			lmi_reg <= 1'b0;
			vmode_d_reg <= 1'b0;
			emode_d_reg <= 1'b0;
			state_reg <= SVS_IDLE;
			chk_reg <= '0;
		end
		else if (ce)
		begin
			sel_reg <= sel_next;
			act_reg <= act_next;
			lmi_reg <= lmi_next;
			vmode_d_reg <= vmode_d_next;
			emode_d_reg <= emode_d_next;
			state_reg <= state_next;
			chk_reg <= chk_next;
		end
	end

	always_comb
	begin
		body = 15'h0000;
		body[`SVS_SEL_MSB-1:`SVS_SEL_LSB-1] = sel_next;
		body[`SVS_LMI_BIT-1] = lmi_next;
	end

	svs_parity #(
		.WIDTH(15)
	) u_parity (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.data(body),
		.par(par)
	);

	logic [14:0] body_reg;
	always_ff @(posedge clk)
	begin
		if (rst)
			body_reg <= 15'h0000;
		else if (ce)
			body_reg <= body;
	end

	assign rd_data = {body_reg, par};
	assign active_code = act_reg;
	assign check_active = chk_reg;
endmodule

// ---- svs_defines.svh ----
// Offsets, field positions, reset value and codes of the verification select register.
`ifndef SVS_DEFINES_SVH
`define SVS_DEFINES_SVH
`define SVS_REG_OFFSET 5'h17
`define SVS_RESET_VALUE 16'h0001
`define SVS_SEL_MSB 7
`define SVS_SEL_LSB 4
`define SVS_LMI_BIT 1
`define SVS_PAR_BIT 0
`define SVS_CODE_NONE 4'h0
`define SVS_CODE_MAX 4'hA
`define SVS_NUM_CHECKS 10
`endif

// ---- svs_pkg.sv ----
// Types shared by the verification select register.
package svs_pkg;
	typedef logic [3:0] svs_code_t;
	typedef enum logic [1:0] {
		SVS_IDLE = 2'b00,
		SVS_ARMED = 2'b01
	} svs_state_e;
endpackage

// ---- svs_parity.sv ----
// Odd parity generator for a returned register word.
`timescale 1ns/1ns
module svs_parity #(
	parameter int WIDTH = 15
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [WIDTH-1:0] data,
	output logic par
);
	logic par_reg;
	logic par_next;

	always_comb
	begin
		par_next = ~(^data);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			par_reg <= 1'b1;
		else if (ce)
			par_reg <= par_next;
	end

	assign par = par_reg;
endmodule

// ---- svs_monitor.sv ----
// Checker for the verification select register.
`timescale 1ns/1ns
module svs_monitor(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic msg_done,
	input wire logic msg_discarded,
	input wire logic verification_operating_mode,
	input wire logic entry_operating_mode,
	input wire logic [4:0] wr_addr,
	input wire logic [15:0] wr_data,
	input wire logic [15:0] rd_data,
	input wire logic [3:0] active_code,
	input wire logic [9:0] check_active
);
	wire vm = verification_operating_mode;
	wire em = entry_operating_mode;
	default clocking @(posedge clk); endclocking
	default disable iff (rst || !ce);
	a_par_odd: assert property (^rd_data) else $error("par");
	a_rsv_zero: assert property (!rd_data[15:8] && !rd_data[3:2])
		else $error("rsv");
	a_code_map: assert property (check_active ==
		(active_code inside {[1:10]} ? 10'h001 << (active_code - 1) : 10'h000))
		else $error("map");
	a_apply_rise: assert property ($rose(vm) && !wr_en |=>
		active_code == $past(rd_data[7:4])) else $error("apply");
	a_entry_clr: assert property ($rose(em) |=> !rd_data[7:4])
		else $error("clr");
	a_wr_take: assert property (wr_en && wr_addr == 5'h17 && !$rose(em) |=>
		rd_data[7:4] == $past(wr_data[7:4])) else $error("take");
	a_sel_hold: assert property (!wr_en && !$rose(em) |=>
		$stable(rd_data[7:4])) else $error("hold");
	a_lmi_load: assert property (msg_done |=>
		rd_data[1] == $past(msg_discarded)) else $error("lmi");
	cover property ($rose(vm));
	cover property (msg_done && msg_discarded);
	cover property ($rose(em));
endmodule
bind svs_select_reg svs_monitor i_mon (.*);

// ---- svs_host_model.sv ----
// Host model that issues register writes and message status.
`timescale 1ns/1ns
module svs_host_model(
	input wire logic clk,
	input wire logic go,
	input wire logic bad,
	input wire logic [4:0] a,
	input wire logic [15:0] d,
	output logic wr_en,
	output logic msg_done,
	output logic msg_discarded,
	output logic [4:0] wr_addr,
	output logic [15:0] wr_data
);
	wire ok = d[7:4] <= 4'hA;
	always_ff @(posedge clk)
	begin
		wr_en <= go && ok;
		msg_done <= go;
		msg_discarded <= go && (bad || !ok);
		wr_addr <= a;
		wr_data <= go ? d : ~wr_data;
	end
endmodule

// ---- tb_svs_select_reg.sv ----
// Testbench for the verification select register.
`timescale 1ns/1ns
module tb_svs_select_reg;
	logic clk = 0, rst = 1, go = 0, bad = 0, vm = 0, em = 0, ce = 1;
	logic [4:0] a = 0, wa;
	logic [15:0] d = 0, wd, rd;
	logic we, md, mx;
	logic [3:0] ac;
	logic [9:0] ca;
	int mismatches = 0, compares = 0, cyc = 0;
	initial forever #50 clk = ~clk;
	svs_host_model i_host(.clk(clk), .go(go), .bad(bad), .a(a), .d(d),
		.wr_en(we), .msg_done(md), .msg_discarded(mx), .wr_addr(wa),
		.wr_data(wd));
	svs_select_reg i_dut(.clk(clk), .rst(rst), .ce(ce), .wr_en(we),
		.wr_addr(wa), .wr_data(wd), .msg_done(md), .msg_discarded(mx),
		.verification_operating_mode(vm), .entry_operating_mode(em),
		.rd_data(rd), .active_code(ac), .check_active(ca));
	task chk(input logic [15:0] g, e);
		compares++;
		if (g !== e)
		begin
			mismatches++;
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
		end
	endtask
	function logic [15:0] w(input logic [3:0] s, input logic l);
		return {8'h00, s, 2'h0, l, ~^{s, l}};
	endfunction
	task wr(input logic [4:0] ad, input logic [15:0] dt, input logic b);
		@(posedge clk);
		go <= 1'h1;
		a <= ad;
		d <= dt;
		bad <= b;
		@(posedge clk);
		go <= 1'h0;
		@(posedge clk);
		#1;
	endtask
	task t_codes;
		for (int k = 0; k <= 10; k++)
		begin
			wr(5'h17, 16'(k) << 4, 1'h0);
			chk(rd, w(4'(k), 1'h0));
			chk(16'(ac), 16'h0);
			@(posedge clk);
			vm <= 1'h1;
			@(posedge clk);
			#1;
			chk(16'(ac), 16'(k));
			chk(16'(ca), k ? 16'h1 << (k - 1) : 16'h0);
			@(posedge clk);
			vm <= 1'h0;
		end
		$display("codes done");
	endtask
	task t_misc;
		wr(5'h17, 16'hFF5E, 1'h1);
		chk(rd, w(4'h5, 1'h1));
		wr(5'h16, 16'h0030, 1'h0);
		chk(rd, w(4'h5, 1'h0));
		wr(5'h17, 16'h00C0, 1'h0);
		chk(rd, w(4'h5, 1'h1));
		@(posedge clk);
		em <= 1'h1;
		@(posedge clk);
		#1;
		chk(rd, w(4'h0, 1'h1));
		@(posedge clk);
		em <= 1'h0;
		$display("misc done");
	endtask
	task t_freeze;
		@(posedge clk);
		ce <= 1'h0;
		wr(5'h17, 16'h0020, 1'h0);
		chk(rd, w(4'h0, 1'h1));
		@(posedge clk);
		ce <= 1'h1;
		@(posedge clk);
		#1;
		chk(rd, w(4'h0, 1'h1));
		$display("freeze done");
	endtask
	task close_out;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 2000)
		begin
			mismatches++;
			close_out;
		end
	end
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		#1;
		chk(rd, 16'h0001);
		t_codes;
		t_misc;
		t_freeze;
		close_out;
	end
endmodule
